// *** design/acq_timebase_consts.svh ***
`ifndef ACQ_TIMEBASE_CONSTS_SVH
`define ACQ_TIMEBASE_CONSTS_SVH
// register byte offsets
`define OFF_CTRL      8'h00
`define OFF_OBS       8'h04
`define OFF_FILT      8'h08
`define OFF_FUND      8'h0c
`define OFF_ZRNG      8'h10
`define OFF_STAT      8'h14
`define OFF_DISP      8'h18
`define OFF_WADR      8'h1c
`define OFF_FILL      8'h20
// control bit positions
`define CTRL_START    0
`define CTRL_STOP     1
`define CTRL_EXT      2
`define CTRL_HARM     3
`define CTRL_SPLIT    4
`define CTRL_RLEN     5
// filter field positions
`define FILT_LINE     0
`define FILT_ZC       2
// record lengths in words
`define REC_LEN_100K  22'h0186a0
`define REC_LEN_1M    22'h0f4240
`define REC_LEN_4M    22'h3d0900
// observation time steps and timing
`define OBS_MAX_IDX   5'h18
`define OBS_MIN_NS    40'h2710
`define PCLK_NS       40'ha
// zero crossing hysteresis, 9/256 of range
`define HYST_NUM      20'h9
// reset values
`define OBS_RST       5'h00
`define FUND_RST      32'h000f4240
`define ZRNG_RST      16'h7fff
`endif

// *** design/acq_timebase_pkg.sv ***
`default_nettype none
package acq_timebase_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RUN  = 2'h1,
      ST_DONE = 2'h3
   } acq_state_t;

   typedef struct packed {
      acq_state_t  state;
      logic [2:0]  esync;
      logic        tb_ext;
      logic        harm;
      logic        split;
      logic [1:0]  rec_sel;
      logic [4:0]  obs_sel;
      logic [4:0]  obs_act;
      logic [1:0]  line_sel;
      logic [1:0]  zc_sel;
      logic [1:0]  zc_eff;
      logic [31:0] fund;
      logic [15:0] zrange;
      logic        bank;
      logic [21:0] count;
      logic [39:0] acc;
      logic        wr_en;
      logic [21:0] wr_addr;
      logic [21:0] disp_len;
      logic        obs_valid;
      logic [31:0] fill_cyc;
      logic        zc_pos;
      logic        zc_edge;
      logic [31:0] prdata;
      logic        err;
   } acq_st_t;
endpackage : acq_timebase_pkg
`default_nettype wire

// *** design/sample_acquisition_timebase.sv ***
// The register offsets and register access over APB were decided locally.
`include "acq_timebase_consts.svh"
`default_nettype none
module sample_acquisition_timebase #(
   parameter logic        MEM_EXT_FITTED = 1'b1,
   parameter logic [39:0] HARM_PTS       = 40'h200
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               ext_clk,
   input  wire logic signed [15:0] zc_sample,
   input  wire logic               zc_valid,
   output logic                    wr_en,
   output logic      [21:0]        wr_addr,
   output logic      [21:0]        disp_len,
   output logic                    obs_valid,
   output logic                    running,
   output logic                    zc_edge,
   output logic      [1:0]         line_filter_sel,
   output logic      [1:0]         zc_filter_eff
);
   localparam logic [39:0] OBS_MIN_CYC = `OBS_MIN_NS / `PCLK_NS;

   acq_timebase_pkg::acq_st_t st_ff;
   acq_timebase_pkg::acq_st_t nxt_st;
   logic                      ext_tgl_ff;

   // observation time step to pclk cycles per screen
   function automatic logic [39:0] obs_cycles(input logic [4:0] idx);
      logic [39:0] val;
      logic [4:0]  dec;
      logic [4:0]  rem;
      val = OBS_MIN_CYC;
      dec = idx / 5'h3;
      rem = idx - dec * 5'h3;
      val = val << rem;
      for (int i = 0; i < 8; i++) begin
         if (5'(i) < dec) val = val * 40'ha;
      end
      return val;
   endfunction : obs_cycles

   // link side: toggle per edge, no division, bursts not tolerated upstream
   always_ff @(posedge ext_clk or negedge presetn) begin
      if (!presetn) ext_tgl_ff <= 1'b0;
      else ext_tgl_ff <= ~ext_tgl_ff;
   end

   logic        wr_acc;
   logic        setup;
   logic        ext_tick;
   logic        int_tick;
   logic [21:0] len_full;
   logic [21:0] len_eff;
   logic [21:0] base;
   logic [39:0] step;
   logic [39:0] thr;
   logic [39:0] sum;
   logic [39:0] obs_c;
   logic [19:0] hprod;
   logic signed [16:0] hyst;
   logic signed [16:0] smp;

   assign wr_acc = psel && penable && pwrite;
   assign setup  = psel && !penable;
   assign pready = 1'b1;

   // next-state logic for the whole block
   always_comb begin
      nxt_st = st_ff;
      nxt_st.wr_en = 1'b0;
      nxt_st.zc_edge = 1'b0;
      // toggle sync: stage 0 feeds only stage 1
      nxt_st.esync = {st_ff.esync[1:0], ext_tgl_ff};
      ext_tick = st_ff.esync[2] ^ st_ff.esync[1];

      // register writes
      if (wr_acc) begin
         case (paddr)
            `OFF_CTRL: begin
               nxt_st.tb_ext  = pwdata[`CTRL_EXT];
               nxt_st.harm    = pwdata[`CTRL_HARM];
               nxt_st.split   = pwdata[`CTRL_SPLIT];
               nxt_st.rec_sel = MEM_EXT_FITTED ? pwdata[`CTRL_RLEN +: 2] : 2'h0;
               if (nxt_st.rec_sel == 2'h3) nxt_st.rec_sel = 2'h2;
            end
            `OFF_OBS: begin
               // held apart from obs_act until start
               if (pwdata[4:0] <= `OBS_MAX_IDX) nxt_st.obs_sel = pwdata[4:0];
            end
            `OFF_FILT: begin
               nxt_st.line_sel = pwdata[`FILT_LINE +: 2];
               nxt_st.zc_sel   = (pwdata[`FILT_ZC +: 2] == 2'h3) ? 2'h0
                               : pwdata[`FILT_ZC +: 2];
            end
            `OFF_FUND: nxt_st.fund = (pwdata == 32'h0) ? 32'h1 : pwdata;
            `OFF_ZRNG: nxt_st.zrange = pwdata[15:0];
            default: ;
         endcase
      end
      // zero-crossing cutoff falls back to the line cutoff
      nxt_st.zc_eff = (nxt_st.zc_sel == 2'h0) ? nxt_st.line_sel : nxt_st.zc_sel;

      // record length and active half
      case (st_ff.rec_sel)
         2'h1:    len_full = `REC_LEN_1M;
         2'h2:    len_full = `REC_LEN_4M;
         default: len_full = `REC_LEN_100K;
      endcase
      len_eff = st_ff.split ? (len_full >> 1) : len_full;
      base    = (st_ff.split && st_ff.bank) ? (len_full >> 1) : 22'h0;

      // internal rate: fractional accumulator, at most one sample per cycle
      obs_c = obs_cycles(st_ff.obs_act);
      step  = st_ff.harm ? HARM_PTS : {18'h0, len_eff};
      thr   = st_ff.harm ? {8'h0, st_ff.fund} : obs_c;
      sum   = st_ff.acc + step;
      int_tick = 1'b0;
      if (st_ff.state == acq_timebase_pkg::ST_RUN && !st_ff.tb_ext) begin
         if (sum >= thr) begin
            int_tick = 1'b1;
            nxt_st.acc = ((sum - thr) >= thr) ? 40'h0 : (sum - thr);
         end else begin
            nxt_st.acc = sum;
         end
      end

      // acquisition sequence
      case (st_ff.state)
         acq_timebase_pkg::ST_IDLE, acq_timebase_pkg::ST_DONE: begin
            if (wr_acc && paddr == `OFF_CTRL && pwdata[`CTRL_START]) begin
               nxt_st.state    = acq_timebase_pkg::ST_RUN;
               nxt_st.obs_act  = st_ff.obs_sel;
               nxt_st.bank     = st_ff.split ? ~st_ff.bank : 1'b0;
               nxt_st.count    = 22'h0;
               nxt_st.acc      = 40'h0;
               nxt_st.fill_cyc = 32'h0;
            end
         end
         acq_timebase_pkg::ST_RUN: begin
            nxt_st.fill_cyc = st_ff.fill_cyc + 32'h1;
            if (wr_acc && paddr == `OFF_CTRL && pwdata[`CTRL_STOP]) begin
               nxt_st.state = acq_timebase_pkg::ST_IDLE;
            end else if (st_ff.tb_ext ? ext_tick : int_tick) begin
               nxt_st.wr_en   = 1'b1;
               nxt_st.wr_addr = base + st_ff.count;
               nxt_st.count   = st_ff.count + 22'h1;
               if (st_ff.count == len_eff - 22'h1) nxt_st.state = acq_timebase_pkg::ST_DONE;
            end
         end
         default: nxt_st.state = acq_timebase_pkg::ST_IDLE;
      endcase

      // display length and whether an observation time is shown
      if (st_ff.harm || st_ff.tb_ext) begin
         nxt_st.disp_len  = len_eff;
         nxt_st.obs_valid = 1'b0;
      end else begin
         nxt_st.disp_len  = (obs_c < {18'h0, len_eff}) ? obs_c[21:0] : len_eff;
         nxt_st.obs_valid = 1'b1;
      end

      // zero crossing with hysteresis band
      hprod = {4'h0, st_ff.zrange} * `HYST_NUM;
      hyst  = {5'h0, hprod[19:8]};
      smp   = {zc_sample[15], zc_sample};
      if (zc_valid) begin
         if (!st_ff.zc_pos && smp > hyst) begin
            nxt_st.zc_pos  = 1'b1;
            nxt_st.zc_edge = 1'b1;
         end else if (st_ff.zc_pos && smp < -hyst) begin
            nxt_st.zc_pos = 1'b0;
         end
      end

      // read data staged in the setup cycle, zero wait states
      if (setup) begin
         nxt_st.err = 1'b0;
         case (paddr)
            `OFF_CTRL: nxt_st.prdata = {25'h0, st_ff.rec_sel, st_ff.split, st_ff.harm,
                                        st_ff.tb_ext, 2'h0};
            `OFF_OBS:  nxt_st.prdata = {19'h0, st_ff.obs_act, 3'h0, st_ff.obs_sel};
            `OFF_FILT: nxt_st.prdata = {26'h0, st_ff.zc_eff, st_ff.zc_sel, st_ff.line_sel};
            `OFF_FUND: nxt_st.prdata = st_ff.fund;
            `OFF_ZRNG: nxt_st.prdata = {16'h0, st_ff.zrange};
            `OFF_STAT: nxt_st.prdata = {27'h0, st_ff.zc_pos, st_ff.obs_valid, st_ff.bank,
                                        st_ff.state == acq_timebase_pkg::ST_DONE,
                                        st_ff.state == acq_timebase_pkg::ST_RUN};
            `OFF_DISP: nxt_st.prdata = {10'h0, st_ff.disp_len};
            `OFF_WADR: nxt_st.prdata = {10'h0, st_ff.count};
            `OFF_FILL: nxt_st.prdata = st_ff.fill_cyc;
            default: begin
               nxt_st.prdata = 32'h0;
               nxt_st.err    = 1'b1;
            end
         endcase
      end
   end

   // single state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff          <= '0;
         st_ff.state    <= acq_timebase_pkg::ST_IDLE;
         st_ff.obs_sel  <= `OBS_RST;
         st_ff.obs_act  <= `OBS_RST;
         st_ff.fund     <= `FUND_RST;
         st_ff.zrange   <= `ZRNG_RST;
         st_ff.disp_len <= `REC_LEN_100K;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prdata          = st_ff.prdata;
   assign pslverr         = st_ff.err;
   assign wr_en           = st_ff.wr_en;
   assign wr_addr         = st_ff.wr_addr;
   assign disp_len        = st_ff.disp_len;
   assign obs_valid       = st_ff.obs_valid;
   assign running         = (st_ff.state == acq_timebase_pkg::ST_RUN);
   assign zc_edge         = st_ff.zc_edge;
   assign line_filter_sel = st_ff.line_sel;
   assign zc_filter_eff   = st_ff.zc_eff;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ext_edge_sample: assert property (
      (running && st_ff.tb_ext && (st_ff.esync[2] ^ st_ff.esync[1])
       && !(wr_acc && paddr == `OFF_CTRL)) |=> wr_en)
      else $error("external edge gave no sample");

   a_ext_no_int: assert property (
      (running && st_ff.tb_ext && !(st_ff.esync[2] ^ st_ff.esync[1])) |=> !wr_en)
      else $error("sample without external edge");

   a_split_range: assert property (
      (wr_en && st_ff.split) |-> (st_ff.bank ? wr_addr >= (len_full >> 1)
                                             : wr_addr < (len_full >> 1)))
      else $error("write outside selected half");

   a_full_range: assert property (
      wr_en |-> wr_addr < len_full)
      else $error("write beyond record length");

   a_disp_equal: assert property (
      $stable(st_ff.harm) && $stable(st_ff.tb_ext) && $stable(len_eff)
      && (st_ff.harm || st_ff.tb_ext) |=> disp_len == $past(len_eff))
      else $error("display length differs from record length");

   a_disp_limit: assert property (
      $stable(len_eff) |=> disp_len <= $past(len_eff))
      else $error("display length exceeds record length");

   a_obs_latched: assert property (
      (!running && wr_acc && paddr == `OFF_CTRL && pwdata[`CTRL_START])
      |=> running && st_ff.obs_act == $past(st_ff.obs_sel)
      ##1 (running && $stable(st_ff.obs_act)) or !running)
      else $error("observation time not latched at start");

   a_zc_fallback: assert property (
      (st_ff.zc_sel == 2'h0) |-> zc_filter_eff == line_filter_sel)
      else $error("zero-crossing filter fallback wrong");

   a_obs_hidden: assert property (
      (st_ff.tb_ext || st_ff.harm) ##1 $stable(st_ff.tb_ext) && $stable(st_ff.harm)
      |-> !obs_valid)
      else $error("observation time shown with external or harmonic");
endmodule : sample_acquisition_timebase
`default_nettype wire

// *** tb/ext_sample_clock_src.sv ***
`default_nettype none
// far-side sample clock: free running, never gated into bursts
module ext_sample_clock_src #(
   parameter time HALF = 15
) (
   output var logic clk
);
   timeunit 1ns;
   timeprecision 1ps;

   // continuous source, the device gets no divider to hide gaps
   initial begin
      clk = 1'b0;
      #3;
      forever #(HALF) clk = ~clk;
   end
endmodule : ext_sample_clock_src
`default_nettype wire

// *** tb/tb_sample_acquisition_timebase.sv ***
`default_nettype none
module tb_sample_acquisition_timebase;
   timeunit 1ns;
   timeprecision 1ps;

   logic               pclk      = 1'b0;
   logic               presetn   = 1'b0;
   logic               psel      = 1'b0;
   logic               penable   = 1'b0;
   logic               pwrite    = 1'b0;
   logic [7:0]         paddr     = 8'h00;
   logic [31:0]        pwdata    = 32'h0;
   logic signed [15:0] zc_sample = 16'sh0;
   logic               zc_valid  = 1'b0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, er, ext_clk, wr_en, obs_valid, running, zc_edge;
   logic [21:0] wr_addr, disp_len, last_addr;
   logic [1:0]  line_filter_sel, zc_filter_eff, zs;
   int failures = 0, check_count = 0, pulses = 0, zedges = 0, addr_err = 0, p0, n;
   bit          had = 0;
   logic [21:0] obs_exp [4] = '{22'h0003e8, 22'h0007d0, 22'h000fa0, 22'h002710};

   always #5 pclk = ~pclk;

   ext_sample_clock_src u_src (.clk(ext_clk));

   sample_acquisition_timebase u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_clk(ext_clk), .zc_sample(zc_sample), .zc_valid(zc_valid),
      .wr_en(wr_en), .wr_addr(wr_addr), .disp_len(disp_len), .obs_valid(obs_valid),
      .running(running), .zc_edge(zc_edge), .line_filter_sel(line_filter_sel),
      .zc_filter_eff(zc_filter_eff)
   );

   // pulse counting and address continuity within one run
   always @(posedge pclk) begin
      if (zc_edge === 1'b1) zedges++;
      if (wr_en === 1'b1) begin
         if (had && wr_addr !== last_addr + 22'h1) addr_err++;
         last_addr = wr_addr;
         had = 1;
         pulses++;
      end else if (running !== 1'b1) had = 0;
   end

   task automatic end_sim;
      if (failures == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim

   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // one apb transfer; an idle edge first so psel never toggles twice per step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no assumed latency: only the watchdog ends a stuck access
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // bounded wait for the next sample strobe
   task automatic wait_wr;
      int k;
      k = 0;
      while (wr_en !== 1'b1 && k < 200) begin
         @(posedge pclk);
         k++;
      end
      check(wr_en, 1'b1);
   endtask : wait_wr

   initial begin
      #400us;
      failures++;
      end_sim();
   end

   initial begin
      repeat (8) @(posedge pclk);
      check(disp_len, 22'h0186a0);
      check(wr_en, 1'b0);
      presetn <= 1'b1;
      apb(1'b0, 8'h24, 32'h0);
      check(er, 1'b1);
      // every line and zero-cross code, code 3 of the latter is refused
      for (int l = 0; l < 4; l++) begin
         for (int z = 0; z < 4; z++) begin
            apb(1'b1, 8'h08, {28'h0, z[1:0], l[1:0]});
            @(posedge pclk);
            zs = (z == 3) ? 2'h0 : z[1:0];
            check(line_filter_sel, l[1:0]);
            check(zc_filter_eff, (zs == 2'h0) ? l[1:0] : zs);
         end
      end
      // first four observation steps, one sample every pclk
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 8'h04, i);
         apb(1'b1, 8'h00, 32'h1);
         wait_wr();
         check(wr_addr, 22'h0);
         @(posedge pclk);
         check(wr_addr, 22'h1);
         check(disp_len, obs_exp[i]);
         check(obs_valid, 1'b1);
         apb(1'b1, 8'h00, 32'h2);
      end
      // new observation time waits for the next start
      apb(1'b1, 8'h04, 32'h18);
      apb(1'b0, 8'h04, 32'h0);
      check(rd[12:8], 5'h03);
      check(rd[4:0], 5'h18);
      apb(1'b1, 8'h00, 32'h61);
      apb(1'b0, 8'h04, 32'h0);
      check(rd[12:8], 5'h18);
      apb(1'b0, 8'h00, 32'h0);
      check(rd[6:5], 2'h2);
      check(disp_len, 22'h3d0900);
      apb(1'b1, 8'h00, 32'h42);
      apb(1'b1, 8'h00, 32'h21);
      apb(1'b0, 8'h00, 32'h0);
      check(disp_len, 22'h0f4240);
      apb(1'b1, 8'h00, 32'h22);
      // harmonic mode shows the whole record and no observation time
      apb(1'b1, 8'h00, 32'h29);
      apb(1'b0, 8'h00, 32'h0);
      check(disp_len, 22'h0f4240);
      check(obs_valid, 1'b0);
      // fill time counts edges in run: four pass before the setup edge
      apb(1'b0, 8'h20, 32'h0);
      check(rd, 32'h4);
      apb(1'b1, 8'h00, 32'h2a);
      // external timebase: one sample per 30 ns cycle, no divider
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h00, 32'h5);
      repeat (20) @(posedge pclk);
      p0 = pulses;
      repeat (300) @(posedge pclk);
      n = pulses - p0;
      check(n >= 99 && n <= 101, 1'b1);
      check(disp_len, 22'h0186a0);
      check(obs_valid, 1'b0);
      check(running, 1'b1);
      apb(1'b1, 8'h00, 32'h6);
      // split memory: split set with the start keeps the lower half, the next run the upper
      apb(1'b1, 8'h00, 32'h11);
      wait_wr();
      check(wr_addr, 22'h0);
      apb(1'b1, 8'h00, 32'h12);
      apb(1'b1, 8'h00, 32'h11);
      wait_wr();
      check(wr_addr, 22'h00c350);
      apb(1'b1, 8'h00, 32'h12);
      check(addr_err, 0);
      // a zero fundamental period is refused and stored as one
      apb(1'b1, 8'h0c, 32'h0);
      apb(1'b0, 8'h0c, 32'h0);
      check(rd, 32'h1);
      // zero crossing threshold is 1151 counts of the default range
      zc_valid <= 1'b1;
      zc_sample <= -16'sd2000;
      repeat (3) @(posedge pclk);
      p0 = zedges;
      zc_sample <= 16'sd1151;
      repeat (3) @(posedge pclk);
      check(zedges - p0, 0);
      zc_sample <= 16'sd1152;
      repeat (3) @(posedge pclk);
      check(zedges - p0, 1);
      end_sim();
   end
endmodule : tb_sample_acquisition_timebase
`default_nettype wire
